/* File: ltgc_link_model.sv */
// link core model: takes source words and loops them back to the sink, with optional faults
`timescale 1ns/10ps
module ltgc_link_model #(
   parameter int LANES = 2
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // source side
   input wire logic src_valid,
   input wire logic [LANES*ltgc_pkg::WORD_W-1:0] src_data,
   input wire logic burst_begin_flag,
   output logic src_ready,
   output logic src_link_up,
   // sink side
   output logic snk_valid,
   output logic [LANES*ltgc_pkg::WORD_W-1:0] snk_data,
   output logic snk_burst_begin_flag,
   output logic snk_link_up,
   // fault select: 1 lane id flip, 2 lane skew, 3 word count cleared in all lanes
   input wire logic [1:0] corrupt
);
   localparam int W = ltgc_pkg::WORD_W;
   logic [1:0] pace_r;
   logic [LANES*W-1:0] word;
   always_comb begin
      word = src_data;
      if (corrupt == 2'h1) word[W+59] = ~word[W+59];
      if (corrupt == 2'h2) word[W+:32] = word[W+:32] + 32'h00000001;
      if (corrupt == 2'h3) begin
         for (int i = 0; i < LANES; i++) word[i*W+:32] = 32'h00000000;
      end
   end
   // one stall in four keeps the generator honest about held words
   assign src_ready = (pace_r != 2'h3) && src_link_up;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pace_r <= 2'h0;
         src_link_up <= 1'b0;
         snk_link_up <= 1'b0;
         snk_valid <= 1'b0;
         snk_data <= '0;
         snk_burst_begin_flag <= 1'b0;
      end else begin
         pace_r <= pace_r + 2'h1;
         src_link_up <= 1'b1;
         snk_link_up <= 1'b1;
         snk_valid <= src_valid && src_ready;
         if (src_valid && src_ready) begin
            snk_data <= word;
            snk_burst_begin_flag <= burst_begin_flag;
         end else begin
            // idle lines toggle so stale data never looks valid
            snk_data <= ~snk_data;
            snk_burst_begin_flag <= 1'b0;
         end
      end
   end
endmodule : ltgc_link_model

/* File: ltgc_pkg.sv */
// shared constants, types and field helpers for the lane traffic generator and checker
package ltgc_pkg;
   // sample word layout
   localparam int WORD_W = 64;
   localparam int ID_W = 5;
   localparam int BC_W = 27;
   localparam int WC_W = 32;
   localparam int ID_LO = 59;
   localparam int BC_LO = 32;
   localparam int WC_LO = 0;
   // values after reset, and the saturation limit of the error counters
   localparam logic [BC_W-1:0] BCNT_RST = 27'h0000001;
   localparam logic [WC_W-1:0] WCNT_RST = 32'h00000001;
   localparam logic [15:0] ERRCNT_MAX = 16'hFFFF;
   // wishbone byte addresses
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_SWAP_CNT = 8'h08;
   localparam logic [7:0] ADR_SEQ_CNT = 8'h0C;
   localparam logic [7:0] ADR_ALIGN_CNT = 8'h10;
   localparam logic [7:0] ADR_GEN_WORDS = 8'h14;
   localparam logic [7:0] ADR_IRQ_STATUS = 8'h18;
   localparam logic [7:0] ADR_IRQ_CLEAR = 8'h1C;
   localparam logic [7:0] ADR_IRQ_ENABLE = 8'h20;
   // control register, bit 0 is gen_en
   typedef struct packed {
      logic usr_rst;
      logic snk_rst;
      logic src_rst;
      logic cont_mode;
      logic crc_ins;
      logic chk_en;
      logic gen_en;
   } ltgc_ctrl_s;
   localparam int CTRL_W = 7;
   localparam ltgc_ctrl_s CTRL_RST = 7'h00;
   // checker events, bit 0 is lane swap
   typedef struct packed {
      logic align;
      logic seq;
      logic swap;
   } ltgc_evt_s;
   localparam int EVT_W = 3;
   typedef enum logic {GEN_IDLE, GEN_RUN} ltgc_gen_e;

   function automatic logic [ID_W-1:0] word_id(input logic [WORD_W-1:0] w);
      return w[ID_LO +: ID_W];
   endfunction : word_id

   function automatic logic [BC_W-1:0] word_bcnt(input logic [WORD_W-1:0] w);
      return w[BC_LO +: BC_W];
   endfunction : word_bcnt

   function automatic logic [WC_W-1:0] word_wcnt(input logic [WORD_W-1:0] w);
      return w[WC_LO +: WC_W];
   endfunction : word_wcnt

   function automatic logic [15:0] sat_inc(input logic [15:0] c);
      return (c == ERRCNT_MAX) ? c : c + 16'h0001;
   endfunction : sat_inc
endpackage : ltgc_pkg

/* File: ltgc_top.sv */
// lane traffic generator, traffic checker and their management registers
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module ltgc_top #(
   parameter int LANES = 2,
   parameter int BURST_LEN = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // source user interface
   output logic src_valid,
   output logic [LANES*ltgc_pkg::WORD_W-1:0] src_data,
   output logic burst_begin_flag,
   input wire logic src_ready,
   input wire logic src_link_up,
   // sink user interface
   input wire logic snk_valid,
   input wire logic [LANES*ltgc_pkg::WORD_W-1:0] snk_data,
   input wire logic snk_burst_begin_flag,
   input wire logic snk_link_up,
   // management outputs
   output logic src_core_reset_n,
   output logic snk_core_reset_n,
   output logic usr_core_reset_n,
   output logic [LANES-1:0] crc_inject_lanes,
   output ltgc_pkg::ltgc_evt_s chk_err,
   output logic irq
);
   typedef struct packed {
      ltgc_pkg::ltgc_gen_e gst;
      logic src_valid;
      logic src_bb;
      logic [LANES*ltgc_pkg::WORD_W-1:0] src_data;
      logic [ltgc_pkg::BC_W-1:0] bcnt;
      logic [ltgc_pkg::WC_W-1:0] wcnt;
      logic [15:0] beat;
      logic bstarted;
      logic prev_ok;
      logic [ltgc_pkg::BC_W-1:0] prev_bcnt;
      logic [ltgc_pkg::WC_W-1:0] prev_wcnt;
      logic [15:0] swap_cnt;
      logic [15:0] seq_cnt;
      logic [15:0] align_cnt;
      ltgc_pkg::ltgc_evt_s chk_err;
      ltgc_pkg::ltgc_ctrl_s ctrl;
      logic [ltgc_pkg::EVT_W-1:0] irq_st;
      logic [ltgc_pkg::EVT_W-1:0] irq_en;
      logic irq;
      logic ack;
      logic [31:0] rdat;
      logic src_rst_n;
      logic snk_rst_n;
      logic usr_rst_n;
      logic [LANES-1:0] crc_lanes;
   } ltgc_state_s;

   ltgc_state_s s_r;
   ltgc_state_s s_nxt;
   logic gen_id_ok;
   logic chk_id_ok;
   logic chk_align_ok;
   logic [ltgc_pkg::WORD_W-1:0] w0;
   assign w0 = snk_data[ltgc_pkg::WORD_W-1:0];

   // lane checks shared by the checker and its assertions
   always_comb begin
      gen_id_ok = 1'b1;
      chk_id_ok = 1'b1;
      chk_align_ok = 1'b1;
      for (int i = 0; i < LANES; i++) begin
         if (ltgc_pkg::word_id(s_r.src_data[i*ltgc_pkg::WORD_W +: ltgc_pkg::WORD_W]) != ltgc_pkg::ID_W'(i)) begin
            gen_id_ok = 1'b0;
         end
         if (ltgc_pkg::word_id(snk_data[i*ltgc_pkg::WORD_W +: ltgc_pkg::WORD_W]) != ltgc_pkg::ID_W'(i)) begin
            chk_id_ok = 1'b0;
         end
         if (i > 0) begin
            if (ltgc_pkg::word_wcnt(snk_data[i*ltgc_pkg::WORD_W +: ltgc_pkg::WORD_W]) !=
                ltgc_pkg::word_wcnt(snk_data[(i-1)*ltgc_pkg::WORD_W +: ltgc_pkg::WORD_W]) ||
                ltgc_pkg::word_bcnt(snk_data[i*ltgc_pkg::WORD_W +: ltgc_pkg::WORD_W]) !=
                ltgc_pkg::word_bcnt(snk_data[(i-1)*ltgc_pkg::WORD_W +: ltgc_pkg::WORD_W])) begin
               chk_align_ok = 1'b0;
            end
         end
      end
   end

   always_comb begin
      logic bus_req;
      logic wr;
      logic accept;
      logic first;
      logic [ltgc_pkg::BC_W-1:0] bc;
      ltgc_pkg::ltgc_evt_s evt;
      logic [ltgc_pkg::EVT_W-1:0] clr;
      bus_req = wb_cyc_i & wb_stb_i;
      wr = 1'b0;
      accept = 1'b0;
      first = 1'b0;
      bc = s_r.bcnt;
      evt = '0;
      clr = '0;
      s_nxt = s_r;

      // wishbone: ack one cycle after the request, write lands at the edge that samples ack
      s_nxt.ack = bus_req & ~s_r.ack;
      wr = bus_req & wb_we_i & s_r.ack & wb_sel_i[0];
      if (bus_req & ~s_r.ack) begin
         case (wb_adr_i)
            ltgc_pkg::ADR_CTRL: s_nxt.rdat = 32'(s_r.ctrl);
            ltgc_pkg::ADR_STATUS: s_nxt.rdat = {28'h0000000, s_r.prev_ok, s_r.src_valid, snk_link_up, src_link_up};
            ltgc_pkg::ADR_SWAP_CNT: s_nxt.rdat = {16'h0000, s_r.swap_cnt};
            ltgc_pkg::ADR_SEQ_CNT: s_nxt.rdat = {16'h0000, s_r.seq_cnt};
            ltgc_pkg::ADR_ALIGN_CNT: s_nxt.rdat = {16'h0000, s_r.align_cnt};
            ltgc_pkg::ADR_GEN_WORDS: s_nxt.rdat = s_r.wcnt;
            ltgc_pkg::ADR_IRQ_STATUS: s_nxt.rdat = 32'(s_r.irq_st);
            ltgc_pkg::ADR_IRQ_ENABLE: s_nxt.rdat = 32'(s_r.irq_en);
            default: s_nxt.rdat = 32'h00000000;
         endcase
      end
      if (wr) begin
         case (wb_adr_i)
            ltgc_pkg::ADR_CTRL: s_nxt.ctrl = wb_dat_i[ltgc_pkg::CTRL_W-1:0];
            ltgc_pkg::ADR_IRQ_CLEAR: clr = wb_dat_i[ltgc_pkg::EVT_W-1:0];
            ltgc_pkg::ADR_IRQ_ENABLE: s_nxt.irq_en = wb_dat_i[ltgc_pkg::EVT_W-1:0];
            default: ;
         endcase
      end

      // derived resets and lane 0 crc insertion
      s_nxt.src_rst_n = ~s_r.ctrl.src_rst;
      s_nxt.snk_rst_n = ~s_r.ctrl.snk_rst;
      s_nxt.usr_rst_n = ~s_r.ctrl.usr_rst;
      s_nxt.crc_lanes = LANES'(s_r.ctrl.crc_ins);

      // generator
      accept = s_r.src_valid & src_ready;
      if (!s_r.src_rst_n) begin
         // only the management reset clears the generator
         s_nxt.gst = ltgc_pkg::GEN_IDLE;
         s_nxt.src_valid = 1'b0;
         s_nxt.src_bb = 1'b0;
         s_nxt.bcnt = ltgc_pkg::BCNT_RST;
         s_nxt.wcnt = ltgc_pkg::WCNT_RST;
         s_nxt.beat = 16'h0000;
         s_nxt.bstarted = 1'b0;
      end else begin
         case (s_r.gst)
            ltgc_pkg::GEN_IDLE: if (s_r.ctrl.gen_en) s_nxt.gst = ltgc_pkg::GEN_RUN;
            ltgc_pkg::GEN_RUN: if (!s_r.ctrl.gen_en) s_nxt.gst = ltgc_pkg::GEN_IDLE;
            default: s_nxt.gst = ltgc_pkg::GEN_IDLE;
         endcase
         // a presented word is held until taken, so counts follow accepted words
         if (!s_r.src_valid || accept) begin
            if (s_r.gst == ltgc_pkg::GEN_RUN && s_r.ctrl.gen_en) begin
               first = (s_r.beat == 16'h0000);
               if (first && s_r.bstarted && !s_r.ctrl.cont_mode) begin
                  bc = s_r.bcnt + 27'h0000001;
               end
               for (int i = 0; i < LANES; i++) begin
                  s_nxt.src_data[i*ltgc_pkg::WORD_W +: ltgc_pkg::WORD_W] = {ltgc_pkg::ID_W'(i), bc, s_r.wcnt};
               end
               s_nxt.src_valid = 1'b1;
               s_nxt.src_bb = s_r.ctrl.cont_mode ? !s_r.bstarted : first;
               s_nxt.bcnt = bc;
               s_nxt.wcnt = s_r.wcnt + 32'h00000001;
               s_nxt.bstarted = 1'b1;
               if (s_r.ctrl.cont_mode || s_r.beat == 16'(BURST_LEN - 1)) begin
                  s_nxt.beat = 16'h0000;
               end else begin
                  s_nxt.beat = s_r.beat + 16'h0001;
               end
            end else begin
               s_nxt.src_valid = 1'b0;
               s_nxt.src_bb = 1'b0;
            end
         end
      end

      // checker
      if (!s_r.snk_rst_n) begin
         s_nxt.prev_ok = 1'b0;
         s_nxt.prev_bcnt = '0;
         s_nxt.prev_wcnt = '0;
      end else if (s_r.ctrl.chk_en && snk_valid) begin
         evt.swap = ~chk_id_ok;
         evt.align = ~chk_align_ok;
         if (s_r.prev_ok) begin
            if (ltgc_pkg::word_wcnt(w0) <= s_r.prev_wcnt) begin
               evt.seq = 1'b1;
            end
            if (snk_burst_begin_flag && ltgc_pkg::word_bcnt(w0) <= s_r.prev_bcnt) begin
               evt.seq = 1'b1;
            end
            if (!snk_burst_begin_flag && ltgc_pkg::word_bcnt(w0) != s_r.prev_bcnt) begin
               evt.seq = 1'b1;
            end
         end
         s_nxt.prev_ok = 1'b1;
         s_nxt.prev_bcnt = ltgc_pkg::word_bcnt(w0);
         s_nxt.prev_wcnt = ltgc_pkg::word_wcnt(w0);
      end
      s_nxt.chk_err = evt;

      // error counters: a write clears, a same-cycle error still counts
      if (wr && wb_adr_i == ltgc_pkg::ADR_SWAP_CNT) s_nxt.swap_cnt = 16'h0000;
      if (wr && wb_adr_i == ltgc_pkg::ADR_SEQ_CNT) s_nxt.seq_cnt = 16'h0000;
      if (wr && wb_adr_i == ltgc_pkg::ADR_ALIGN_CNT) s_nxt.align_cnt = 16'h0000;
      if (evt.swap) s_nxt.swap_cnt = ltgc_pkg::sat_inc(s_nxt.swap_cnt);
      if (evt.seq) s_nxt.seq_cnt = ltgc_pkg::sat_inc(s_nxt.seq_cnt);
      if (evt.align) s_nxt.align_cnt = ltgc_pkg::sat_inc(s_nxt.align_cnt);

      // sticky status, set wins over clear
      s_nxt.irq_st = (s_r.irq_st & ~clr) | evt;
      s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);
   end

   // rst stands in for the master reset; all derived resets are asserted under it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_r <= '{gst: ltgc_pkg::GEN_IDLE, bcnt: ltgc_pkg::BCNT_RST, wcnt: ltgc_pkg::WCNT_RST,
                  ctrl: ltgc_pkg::CTRL_RST, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o = s_r.rdat;
   assign wb_ack_o = s_r.ack;
   assign src_valid = s_r.src_valid;
   assign src_data = s_r.src_data;
   assign burst_begin_flag = s_r.src_bb;
   assign src_core_reset_n = s_r.src_rst_n;
   assign snk_core_reset_n = s_r.snk_rst_n;
   assign usr_core_reset_n = s_r.usr_rst_n;
   assign crc_inject_lanes = s_r.crc_lanes;
   assign chk_err = s_r.chk_err;
   assign irq = s_r.irq;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   lane_id_a: assert property (s_r.src_valid |-> gen_id_ok)
      else $error("generator lane id wrong");
   // a management reset may drop a held word, so only a generator out of management reset must hold it
   hold_word_a: assert property (s_r.src_rst_n && s_r.src_valid && !src_ready
      |=> s_r.src_valid && $stable(s_r.src_data))
      else $error("unaccepted word changed");
   wcnt_step_a: assert property (s_r.src_valid && src_ready && s_r.src_rst_n ##1 s_r.src_valid && s_r.src_rst_n
      |-> ltgc_pkg::word_wcnt(s_r.src_data[63:0]) == $past(ltgc_pkg::word_wcnt(s_r.src_data[63:0])) + 32'h00000001)
      else $error("word count did not step by one");
   bcnt_step_a: assert property (s_r.src_rst_n && $past(s_r.src_rst_n) && s_r.bcnt != $past(s_r.bcnt)
      |-> s_r.src_bb && s_r.bcnt == $past(s_r.bcnt) + 27'h0000001)
      else $error("burst count moved without burst begin");
   cont_hold_a: assert property (s_r.ctrl.cont_mode && $past(s_r.ctrl.cont_mode) && s_r.src_rst_n
      && $past(s_r.src_rst_n) |-> s_r.bcnt == $past(s_r.bcnt))
      else $error("burst count moved in continuous mode");
   swap_flag_a: assert property (s_r.snk_rst_n && s_r.ctrl.chk_en && snk_valid && !chk_id_ok |=> chk_err.swap)
      else $error("lane swap not flagged");
   align_flag_a: assert property (s_r.snk_rst_n && s_r.ctrl.chk_en && snk_valid && !chk_align_ok |=> chk_err.align)
      else $error("lane alignment not flagged");
   seq_flag_a: assert property (s_r.snk_rst_n && s_r.ctrl.chk_en && snk_valid && s_r.prev_ok
      && ltgc_pkg::word_wcnt(w0) <= s_r.prev_wcnt |=> chk_err.seq ##1 s_r.irq_st[1])
      else $error("word count regression not flagged");
   burst_seq_a: assert property (s_r.snk_rst_n && s_r.ctrl.chk_en && snk_valid && s_r.prev_ok
      && !snk_burst_begin_flag && ltgc_pkg::word_bcnt(w0) != s_r.prev_bcnt |=> chk_err.seq)
      else $error("burst count change not flagged");
   src_reset_a: assert property (s_r.ctrl.src_rst |=> !src_core_reset_n ##1 !src_valid)
      else $error("generator reset not applied");
   crc_lane_a: assert property (crc_inject_lanes[0] == $past(s_r.ctrl.crc_ins)
      && (crc_inject_lanes >> 1) == '0)
      else $error("crc insertion outside lane 0");

   // interrupt and error bookkeeping
   irq_level_a: assert property (irq == |(s_r.irq_st & s_r.irq_en))
      else $error("irq level does not follow enabled status");
   sticky_set_a: assert property (s_r.chk_err != '0
      |-> (s_r.irq_st & s_r.chk_err) == s_r.chk_err)
      else $error("error pulse without sticky status");
   swap_count_a: assert property (s_r.chk_err.swap
      |-> s_r.swap_cnt != 16'h0000)
      else $error("swap error not counted");
   seq_count_a: assert property (s_r.chk_err.seq
      |-> s_r.seq_cnt != 16'h0000)
      else $error("sequence error not counted");
   align_count_a: assert property (s_r.chk_err.align
      |-> s_r.align_cnt != 16'h0000)
      else $error("alignment error not counted");
   chk_idle_a: assert property (!s_r.ctrl.chk_en
      |=> chk_err == 3'h0)
      else $error("disabled checker raised an error");

   // management resets trail the control bits by one cycle; the first cycle after rst is skipped
   snk_reset_a: assert property (!$past(rst)
      |-> snk_core_reset_n == !$past(s_r.ctrl.snk_rst))
      else $error("checker reset does not follow control");
   usr_reset_a: assert property (!$past(rst)
      |-> usr_core_reset_n == !$past(s_r.ctrl.usr_rst))
      else $error("user reset does not follow control");
   bb_valid_a: assert property (burst_begin_flag
      |-> src_valid)
      else $error("burst begin without a valid word");
   ack_pulse_a: assert property (wb_ack_o
      |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");

   burst_cov_c: cover property (src_valid && src_ready && burst_begin_flag && s_r.bcnt > 27'h0000001);
   cont_cov_c: cover property (s_r.ctrl.cont_mode && src_valid && src_ready [*4]);
   seq_err_cov_c: cover property (chk_err.seq ##1 irq);
   stall_cov_c: cover property (src_valid && !src_ready ##1 src_valid && src_ready);
   clear_race_c: cover property (wb_ack_o && wb_we_i && wb_adr_i == ltgc_pkg::ADR_IRQ_CLEAR && |s_nxt.chk_err);
endmodule : ltgc_top

/* File: ltgc_top_tb.sv */
// self-checking bench for the lane traffic generator and checker
`timescale 1ns/10ps
module ltgc_top_tb;
   localparam int LANES = 2;
   localparam int BLEN = 4;
   localparam int W = ltgc_pkg::WORD_W;
   logic mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, src_valid, burst_begin_flag, src_ready;
   logic src_link_up, snk_valid, snk_burst_begin_flag, snk_link_up, src_core_reset_n, snk_core_reset_n;
   logic usr_core_reset_n, irq;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, exp_wc, exp_bc, rd;
   logic [LANES*W-1:0] src_data, snk_data;
   logic [LANES-1:0] crc_inject_lanes;
   logic [1:0] corrupt;
   ltgc_pkg::ltgc_evt_s chk_err;
   int n_mismatch = 0, tests_run = 0, n_acc = 0, in_burst = 0, n_err[3] = '{0, 0, 0};
   bit first = 1, cont_m = 0, ebb;
   ltgc_top #(.LANES(LANES), .BURST_LEN(BLEN)) ltgc_top_inst (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_valid(src_valid), .src_data(src_data),
      .burst_begin_flag(burst_begin_flag), .src_ready(src_ready), .src_link_up(src_link_up),
      .snk_valid(snk_valid), .snk_data(snk_data), .snk_burst_begin_flag(snk_burst_begin_flag),
      .snk_link_up(snk_link_up), .src_core_reset_n(src_core_reset_n), .snk_core_reset_n(snk_core_reset_n),
      .usr_core_reset_n(usr_core_reset_n), .crc_inject_lanes(crc_inject_lanes), .chk_err(chk_err), .irq(irq));
   ltgc_link_model #(.LANES(LANES)) ltgc_link_model_inst (.mclk(mclk), .rst(rst), .src_valid(src_valid),
      .src_data(src_data), .burst_begin_flag(burst_begin_flag), .src_ready(src_ready),
      .src_link_up(src_link_up), .snk_valid(snk_valid), .snk_data(snk_data),
      .snk_burst_begin_flag(snk_burst_begin_flag), .snk_link_up(snk_link_up), .corrupt(corrupt));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_flag(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask : chk_flag
   task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int t;
      t = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge mclk);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 50);
      if (t >= 50) n_mismatch++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk);
   endtask : wb_io
   // source monitor: expected fields follow from the stream so far, never from the design
   always @(posedge mclk) begin
      if (!src_core_reset_n) begin
         exp_wc = 32'h1;
         exp_bc = 32'h1;
         first = 1;
         in_burst = 0;
      end else if (src_valid && src_ready) begin
         ebb = first || (!cont_m && in_burst == 0);
         chk_flag(burst_begin_flag, ebb);
         if (ebb && !first) exp_bc++;
         for (int i = 0; i < LANES; i++) begin
            chk_word({27'h0, src_data[i*W+59+:5]}, 32'(i));
            chk_word({5'h0, src_data[i*W+32+:27]}, exp_bc);
            chk_word(src_data[i*W+:32], exp_wc);
         end
         exp_wc++;
         first = 0;
         in_burst = (in_burst + 1) % BLEN;
         n_acc++;
      end
      for (int b = 0; b < 3; b++) if (chk_err[b] === 1'b1) n_err[b]++;
   end
   task automatic run_until(input int n);
      int t;
      t = 0;
      n_acc = 0;
      while (n_acc < n && t < 8000) begin
         @(posedge mclk);
         t++;
      end
      if (t >= 8000) n_mismatch++;
   endtask : run_until
   task automatic inject(input logic [1:0] m);
      int t;
      t = 0;
      corrupt <= m;
      do begin
         @(posedge mclk);
         t++;
      end while (!(src_valid && src_ready) && t < 100);
      corrupt <= 2'h0;
      repeat (5) @(posedge mclk);
   endtask : inject
   task automatic chk_errs(input int s, input int q, input int a);
      chk_word(32'(n_err[0]), 32'(s));
      chk_word(32'(n_err[1]), 32'(q));
      chk_word(32'(n_err[2]), 32'(a));
   endtask : chk_errs
   task automatic scen_regs();
      @(posedge mclk);
      chk_flag(src_core_reset_n, 1'b1);
      wb_io(1'b0, ltgc_pkg::ADR_CTRL, 32'h0);
      chk_word(rd, 32'h0);
      wb_io(1'b0, ltgc_pkg::ADR_STATUS, 32'h0);
      chk_word(rd & 32'h3, 32'h3);
      wb_io(1'b0, 8'h40, 32'h0);
      chk_word(rd, 32'h0);
      wb_io(1'b1, ltgc_pkg::ADR_CTRL, 32'h70);
      @(posedge mclk);
      chk_flag(src_core_reset_n, 1'b0);
      chk_flag(snk_core_reset_n, 1'b0);
      chk_flag(usr_core_reset_n, 1'b0);
      wb_io(1'b1, ltgc_pkg::ADR_CTRL, 32'h0);
   endtask : scen_regs
   task automatic scen_stream();
      wb_io(1'b1, ltgc_pkg::ADR_CTRL, 32'h3);
      run_until(2000);
      wb_io(1'b1, ltgc_pkg::ADR_CTRL, 32'h2);
      repeat (10) @(posedge mclk);
      chk_errs(0, 0, 0);
      wb_io(1'b0, ltgc_pkg::ADR_GEN_WORDS, 32'h0);
      chk_word(rd, exp_wc);
      wb_io(1'b0, ltgc_pkg::ADR_STATUS, 32'h0);
      chk_word(rd & 32'h8, 32'h8);
   endtask : scen_stream
   task automatic scen_faults();
      wb_io(1'b1, ltgc_pkg::ADR_CTRL, 32'h3);
      wb_io(1'b1, ltgc_pkg::ADR_IRQ_ENABLE, 32'h1);
      inject(2'h1);
      chk_errs(1, 0, 0);
      chk_flag(irq, 1'b1);
      wb_io(1'b0, ltgc_pkg::ADR_SWAP_CNT, 32'h0);
      chk_word(rd, 32'h1);
      wb_io(1'b1, ltgc_pkg::ADR_IRQ_CLEAR, 32'h1);
      @(posedge mclk);
      chk_flag(irq, 1'b0);
      inject(2'h2);
      inject(2'h3);
      chk_errs(1, 1, 1);
      chk_flag(irq, 1'b0);
      wb_io(1'b0, ltgc_pkg::ADR_IRQ_STATUS, 32'h0);
      chk_word(rd, 32'h6);
      wb_io(1'b0, ltgc_pkg::ADR_SEQ_CNT, 32'h0);
      chk_word(rd, 32'h1);
      wb_io(1'b1, ltgc_pkg::ADR_ALIGN_CNT, 32'h0);
      wb_io(1'b0, ltgc_pkg::ADR_ALIGN_CNT, 32'h0);
      chk_word(rd, 32'h0);
      wb_io(1'b1, ltgc_pkg::ADR_CTRL, 32'h4);
      @(posedge mclk);
      chk_word({30'h0, crc_inject_lanes}, 32'h1);
   endtask : scen_faults
   task automatic scen_cont();
      // continuous mode is entered with both ends held in reset
      wb_io(1'b1, ltgc_pkg::ADR_CTRL, 32'h38);
      cont_m = 1;
      wb_io(1'b1, ltgc_pkg::ADR_CTRL, 32'h0B);
      run_until(3 * BLEN);
      wb_io(1'b1, ltgc_pkg::ADR_CTRL, 32'h0);
      repeat (10) @(posedge mclk);
      chk_errs(1, 1, 1);
   endtask : scen_cont
   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #(8 * 30000);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      corrupt = 2'h0;
      repeat (8) @(posedge mclk);
      chk_flag(src_core_reset_n, 1'b0);
      chk_flag(snk_core_reset_n, 1'b0);
      chk_flag(irq, 1'b0);
      rst <= 1'b0;
      @(posedge mclk);
      scen_regs();
      scen_stream();
      scen_faults();
      scen_cont();
      wrap_up();
   end
endmodule : ltgc_top_tb
